// [verilog/encoder_regs.vh]
// Register offsets, field positions, reset values and codes of the encoder control block.
`ifndef ENCODER_REGS_VH
`define ENCODER_REGS_VH
`define CTRL_OFFSET 12'h000
`define VEL_LOW_OFFSET 12'h004
`define VEL_HIGH_OFFSET 12'h008
`define POS_OFFSET 12'h00c
`define INIT_OFFSET 12'h010
`define CTRL_RESET 16'h0000
`define CTRL_WMASK 16'hbf7f
`define UNIT_ON_BIT 15
`define HALT_IDLE_BIT 13
`define INIT_MODE_HI 12
`define INIT_MODE_LO 10
`define MATCH_HI 9
`define MATCH_LO 8
`define PRESCALE_HI 6
`define PRESCALE_LO 4
`define DIR_INV_BIT 3
`define MODE_MOD_RST 3'h7
`define MODE_MOD 3'h6
`define MODE_SECOND 3'h4
`define MODE_FIRST 3'h3
`define MODE_NEXT 3'h2
`define MODE_EVERY 3'h1
`endif

// [verilog/quad_decoder.v]
// Quadrature phase decoder with input synchronisers.
`timescale 1ns/1ps
module quad_decoder (
  input wire clk,
  input wire arst_n,
  input wire phaseA,
  input wire phaseB,
  input wire indexIn,
  output reg aSync,
  output reg bSync,
  output reg idxSync,
  output wire countUp,
  output wire countDown
);
  reg [2:0] meta;
  reg prevA;
  reg prevB;
  // Two-flop synchronisers, then a history stage for edge decode.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 3'h0;
      aSync <= 1'b0;
      bSync <= 1'b0;
      idxSync <= 1'b0;
      prevA <= 1'b0;
      prevB <= 1'b0;
    end else begin
      meta <= {indexIn, phaseB, phaseA};
      aSync <= meta[0];
      bSync <= meta[1];
      idxSync <= meta[2];
      prevA <= aSync;
      prevB <= bSync;
    end
  end
  // A leading B counts up, B leading A counts down; double changes are dropped.
  wire chA = aSync ^ prevA;
  wire chB = bSync ^ prevB;
  wire dirUp = (chA & (aSync ^ bSync)) | (chB & ~(aSync ^ bSync));
  assign countUp = (chA ^ chB) & dirUp; // [R11]
  assign countDown = (chA ^ chB) & ~dirUp; // [R11]
endmodule // quad_decoder

// [verilog/prescaler.v]
// Power-of-two timer clock prescaler producing a one-cycle enable.
`timescale 1ns/1ps
module prescaler (
  input wire clk,
  input wire arst_n,
  input wire run,
  input wire [2:0] code,
  output wire tick
);
  reg [6:0] count;
  wire [6:0] limit = (7'h01 << code) - 7'h01;
  // Counts 2^code input cycles per enable pulse.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 7'h00;
    end else if (!run || count >= limit) begin
      count <= 7'h00;
    end else begin
      count <= count + 7'h01;
    end
  end
  assign tick = run && (count >= limit); // [R8]
endmodule // prescaler

// [verilog/encoder_control.v]
// Quadrature encoder control block with APB registers.
// Function
// R1 - Unit-on bit runs interface, registers stay accessible
// R2 - Halt-when-idle stops interface during idle
// R3 - Codes 111/110 modulo count; 111 index resets
// R4 - Code 100 second, 011 first index after home
// R5 - Code 010 next index loads; 001 resets
// R6 - Code 000 index leaves counter alone
// R7 - Index match needs phases equal pattern
// R8 - Prescale divides timer clock by 2^n
// R9 - Direction-invert makes counters count negative
// R10 - Velocity hold 32 bits, two halves, reset zero
// R11 - Decode phases into up and down pulses
// R12 - Velocity captured atomically into hold register
`timescale 1ns/1ps
`include "encoder_regs.vh"
module encoder_control (
  input wire clk,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire phaseA,
  input wire phaseB,
  input wire indexIn,
  input wire homeIn,
  input wire idleMode,
  input wire upDownOverride,
  input wire upDownLevel,
  input wire velocityCapture,
  input wire [31:0] moduloLimit,
  output reg [31:0] position,
  output reg [31:0] velocity,
  output wire running
);
  // Register map, one aligned 32-bit word per register.
  // The control word sits at offset 0x000 and keeps its upper half at zero.
  // The low velocity hold half sits at 0x004 and uses data bits 15 to 0.
  // The high velocity hold half sits at 0x008 and uses data bits 15 to 0.
  // The position counter sits at 0x00c and is read only.
  // The init value sits at 0x010 and is a full 32-bit word.
  // Any other address answers with an error and reads as zero.
  //
  // Control word fields.
  // Bit 15 turns the unit on; clearing it freezes the position and velocity counters.
  // Bit 14 is reserved, ignores writes and reads as zero.
  // Bit 13 stops the unit while the device is in its idle state.
  // Bits 12 to 10 pick how index events touch the position counter.
  // Bits 9 and 8 give the phase levels an index event must meet.
  // Bit 9 is the phase B level and bit 8 the phase A level.
  // Bit 7 is reserved, ignores writes and reads as zero.
  // Bits 6 to 4 select the power-of-two timer prescale.
  // Bit 3 inverts the counting direction of all counters.
  // Bits 2 to 0 are stored and read back but drive nothing here.
  //
  // Index modes in short.
  // Code 111 counts modulo and clears the position on every index.
  // Code 110 counts modulo and leaves the position alone on index.
  // Code 101 behaves like code 000 in this block.
  // Code 100 loads the init value on the second index after home.
  // Code 011 loads the init value on the first index after home.
  // Code 010 loads the init value on every index event.
  // Code 001 clears the position on every index event.
  // Code 000 leaves the position alone on index events.
  //
  // Hazards worth knowing.
  // The pins are asynchronous, so every pin but idleMode and moduloLimit passes two flip-flops first.
  // An index pulse is seen once, on its first cycle with a pattern match.
  // A home event only arms the tracker when it is waiting for one.
  // A capture strobe wins over a software write to the hold word.
  // Modulo mode wraps between zero and the modulo limit input.
  //
  // Home tracker states, one-hot.
  localparam HS_WAIT = 3'b001;
  localparam HS_ONE = 3'b010;
  localparam HS_ARMED = 3'b100;
  reg [15:0] control;
  reg [31:0] velocityHold;
  reg [31:0] initValue;
  reg [2:0] homeState;
  reg [2:0] next_homeState;
  reg [1:0] auxMeta;
  reg [1:0] auxSync;
  reg [1:0] extMeta;
  reg [1:0] extSync;
  reg idxPrev;
  reg capPrev;
  reg capSync;
  reg capMeta;
  reg homePrev;
  wire aSync;
  wire bSync;
  wire idxSync;
  wire countUp;
  wire countDown;
  wire tick;
  wire [2:0] mode = control[`INIT_MODE_HI:`INIT_MODE_LO];

  // Index event: first cycle of an index pulse in which the phases equal the match pattern.
  wire idxMatch = ({bSync, aSync} == control[`MATCH_HI:`MATCH_LO]); // [R7]
  wire indexEvt = running && idxSync && !idxPrev && idxMatch; // [R7]
  wire homeEvt = running && auxSync[1] && !homePrev;

  wire access = psel && penable;
  wire wr = access && pwrite;
  wire mapped = (paddr == `CTRL_OFFSET) || (paddr == `VEL_LOW_OFFSET) ||
    (paddr == `VEL_HIGH_OFFSET) || (paddr == `POS_OFFSET) || (paddr == `INIT_OFFSET);
  // Interface runs only when on and not halted by idle.
  assign running = control[`UNIT_ON_BIT] &&
    !(control[`HALT_IDLE_BIT] && idleMode); // [R1] [R2]
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  quad_decoder decode (
    .clk(clk),
    .arst_n(arst_n),
    .phaseA(phaseA),
    .phaseB(phaseB),
    .indexIn(indexIn),
    .aSync(aSync),
    .bSync(bSync),
    .idxSync(idxSync),
    .countUp(countUp),
    .countDown(countDown)
  );

  prescaler divider (
    .clk(clk),
    .arst_n(arst_n),
    .run(running),
    .code(control[`PRESCALE_HI:`PRESCALE_LO]),
    .tick(tick)
  );

  // Synchronises the home, idle-independent direction and capture pins.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      auxMeta <= 2'h0;
      auxSync <= 2'h0;
      extMeta <= 2'h0;
      extSync <= 2'h0;
      capMeta <= 1'b0;
      capSync <= 1'b0;
      capPrev <= 1'b0;
      idxPrev <= 1'b0;
      homePrev <= 1'b0;
    end else begin
      auxMeta <= {homeIn, 1'b0};
      auxSync <= auxMeta;
      extMeta <= {upDownOverride, upDownLevel};
      extSync <= extMeta;
      capMeta <= velocityCapture;
      capSync <= capMeta;
      capPrev <= capSync;
      idxPrev <= indexEvt ? 1'b1 : (idxSync ? idxPrev : 1'b0);
      homePrev <= auxSync[1];
    end
  end

  // Tracks index events after a home event for the first/second modes.
  always @* begin
    next_homeState = homeState;
    case (homeState)
      HS_WAIT: begin
        if (homeEvt) begin
          next_homeState = HS_ONE;
        end
      end
      HS_ONE: begin
        if (indexEvt && mode == `MODE_SECOND) begin
          next_homeState = HS_ARMED;
        end else if (indexEvt) begin
          next_homeState = HS_WAIT;
        end
      end
      HS_ARMED: begin
        if (indexEvt) begin
          next_homeState = HS_WAIT;
        end
      end
      default: begin
        next_homeState = HS_WAIT;
      end
    endcase
  end

  // Load from the init value when the mode's index condition is met.
  wire loadEvt = indexEvt && (
    (mode == `MODE_NEXT) || // [R5]
    (mode == `MODE_FIRST && homeState == HS_ONE) || // [R4]
    (mode == `MODE_SECOND && homeState == HS_ARMED)); // [R4]
  wire resetEvt = indexEvt &&
    (mode == `MODE_EVERY || mode == `MODE_MOD_RST); // [R3] [R5]
  wire moduloOn = (mode == `MODE_MOD) || (mode == `MODE_MOD_RST); // [R3]
  // Direction from invert bit unless the external signal overrides.
  wire negDir = extSync[1] ? extSync[0] : control[`DIR_INV_BIT]; // [R9]
  wire stepUp = negDir ? countDown : countUp; // [R9]
  wire stepDown = negDir ? countUp : countDown; // [R9]
  wire [31:0] incPos = (moduloOn && position >= moduloLimit) ? 32'h0 : position + 32'h1;
  wire [31:0] decPos = (moduloOn && position == 32'h0) ? moduloLimit : position - 32'h1;

  // Position counter; code 000 leaves it untouched by index events.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      position <= 32'h0;
      homeState <= HS_WAIT;
    end else if (running) begin // [R1]
      homeState <= next_homeState;
      if (resetEvt) begin
        position <= 32'h0; // [R3] [R5]
      end else if (loadEvt) begin
        position <= initValue; // [R4] [R5]
      end else if (stepUp) begin
        position <= incPos; // [R11] [R6]
      end else if (stepDown) begin
        position <= decPos; // [R11]
      end
    end
  end

  // Velocity counter advances on prescaled ticks with a pending step.
  reg pendUp;
  reg pendDown;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      velocity <= 32'h0;
      pendUp <= 1'b0;
      pendDown <= 1'b0;
    end else if (running) begin
      if (capSync && !capPrev) begin
        velocity <= 32'h0;
        pendUp <= 1'b0;
        pendDown <= 1'b0;
      end else if (tick) begin // [R8]
        if (pendUp || stepUp) velocity <= velocity + 32'h1;
        else if (pendDown || stepDown) velocity <= velocity - 32'h1;
        pendUp <= 1'b0;
        pendDown <= 1'b0;
      end else begin
        pendUp <= pendUp | stepUp;
        pendDown <= pendDown | stepDown;
      end
    end
  end

  // Register writes; the whole 32-bit velocity is captured in one edge.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      control <= `CTRL_RESET;
      velocityHold <= 32'h0; // [R10]
      initValue <= 32'h0;
    end else begin
      if (running && capSync && !capPrev) begin
        velocityHold <= velocity; // [R12]
      end else if (wr && paddr == `VEL_LOW_OFFSET) begin
        velocityHold[15:0] <= pwdata[15:0]; // [R10]
      end else if (wr && paddr == `VEL_HIGH_OFFSET) begin
        velocityHold[31:16] <= pwdata[15:0]; // [R10]
      end
      if (wr && paddr == `CTRL_OFFSET) begin
        control <= pwdata[15:0] & `CTRL_WMASK; // [R1]
      end
      if (wr && paddr == `INIT_OFFSET) begin
        initValue <= pwdata;
      end
    end
  end

  // Read data registered at the setup phase.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `CTRL_OFFSET) begin
        prdata <= {16'h0, control};
      end else if (paddr == `VEL_LOW_OFFSET) begin
        prdata <= {16'h0, velocityHold[15:0]}; // [R10]
      end else if (paddr == `VEL_HIGH_OFFSET) begin
        prdata <= {16'h0, velocityHold[31:16]}; // [R10]
      end else if (paddr == `POS_OFFSET) begin
        prdata <= position;
      end else if (paddr == `INIT_OFFSET) begin
        prdata <= initValue;
      end else begin
        prdata <= 32'h0;
      end
    end
  end
endmodule // encoder_control

// [bench/encoder_model.sv]
// Behavioural quadrature encoder driving phase, index and home lines.
`timescale 1ns/1ps
module encoder_model (
  input wire clk,
  output reg phaseA,
  output reg phaseB,
  output reg indexIn,
  output reg homeIn
);
  reg [1:0] st = 2'b00;
  // Lines start low at time zero.
  initial begin
    {phaseB, phaseA, indexIn, homeIn} = 4'h0;
  end
  // One Gray step; phase A leads for forward motion.
  task step(input bit up);
    st = up ? st + 2'b01 : st - 2'b01;
    @(posedge clk);
    {phaseB, phaseA} <= {st[1], st[1] ^ st[0]};
    repeat (8) @(posedge clk);
  endtask
  // A wide pulse on the index line, or on the home line when home is set.
  task pulse(input bit home);
    @(posedge clk);
    if (home) homeIn <= 1'b1;
    else indexIn <= 1'b1;
    repeat (8) @(posedge clk);
    {indexIn, homeIn} <= 2'b00;
    repeat (8) @(posedge clk);
  endtask
endmodule // encoder_model

// [bench/encoder_control_asserts.sv]
// Port checker for the encoder control block.
`timescale 1ns/1ps
`include "encoder_regs.vh"
module encoder_control_asserts (
  input wire clk,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire idleMode,
  input wire velocityCapture,
  input wire [31:0] position,
  input wire [31:0] velocity,
  input wire running
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire acc = psel && penable;
  wire bad = !((paddr == `CTRL_OFFSET) || (paddr == `VEL_LOW_OFFSET) ||
    (paddr == `VEL_HIGH_OFFSET) || (paddr == `POS_OFFSET) || (paddr == `INIT_OFFSET));
  reg [15:0] ctrl;
  // Shadow of the control word as last written over the bus.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) ctrl <= 16'h0000;
    else if (acc && pwrite && paddr == `CTRL_OFFSET) ctrl <= pwdata[15:0];
  end
  pready_high_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (acc && bad |-> pslverr) else $error("no error");
  mapped_ok_a: assert property (acc && !bad |-> !pslverr) else $error("bad error");
  unmapped_zero_a: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  ctrl_read_a: assert property (acc && !pwrite && paddr == `CTRL_OFFSET
    |-> prdata == {16'h0, ctrl & `CTRL_WMASK}) else $error("control readback");
  run_gate_a: assert property (running == (ctrl[15] && !(ctrl[13] && idleMode)))
    else $error("running wrong");
  stop_hold_a: assert property (!running |=> $stable(position))
    else $error("position moved while stopped");
  capture_clear_a: assert property ($rose(velocityCapture) && running |-> ##3 velocity == 32'h0)
    else $error("velocity not cleared");
endmodule // encoder_control_asserts
bind encoder_control encoder_control_asserts i_asserts (.clk(clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .idleMode(idleMode), .velocityCapture(velocityCapture),
  .position(position), .velocity(velocity), .running(running));

// [bench/encoder_control_tb.sv]
// Self-checking testbench for the encoder control block.
`timescale 1ns/1ps
`include "encoder_regs.vh"
module encoder_control_tb;
  logic clk, arst_n, psel, penable, pwrite, idleMode, upDownOverride, upDownLevel;
  logic velocityCapture;
  logic [11:0] paddr;
  logic [31:0] pwdata, moduloLimit, rd, p;
  wire [31:0] prdata, position, velocity;
  wire pready, pslverr, running, phaseA, phaseB, indexIn, homeIn;
  logic [4:0] rows [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h19};
  int n_errors = 0;
  int checked = 0;
  encoder_control i_encoder_control (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .phaseA, .phaseB, .indexIn, .homeIn, .idleMode, .upDownOverride,
    .upDownLevel, .velocityCapture, .moduloLimit, .position, .velocity, .running);
  encoder_model i_encoder_model (.clk, .phaseA, .phaseB, .indexIn, .homeIn);
  // Clock of 4 ns period.
  always #2 clk = ~clk;
  // One bus transfer: setup, then access until pready is seen.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task steps(input bit up);
    repeat (4) i_encoder_model.step(up);
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Cuts a hung run short.
  initial begin
    #100000;
    n_errors++;
    report_and_stop;
  end
  // Main test sequence.
  initial begin
    {clk, arst_n, psel, penable, pwrite, idleMode, upDownOverride, upDownLevel} = 8'h0;
    velocityCapture = 1'b0; paddr = 12'h0; pwdata = 32'h0; moduloLimit = 32'h0000_0fff;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rdchk(`CTRL_OFFSET, 32'h0);
    rdchk(`VEL_LOW_OFFSET, 32'h0);
    rdchk(`VEL_HIGH_OFFSET, 32'h0);
    rdchk(12'h020, 32'h0);
    apb(1'b1, `CTRL_OFFSET, 32'hffff);
    rdchk(`CTRL_OFFSET, 32'h0000bf7f);
    apb(1'b1, `VEL_LOW_OFFSET, 32'h1234);
    apb(1'b1, `VEL_HIGH_OFFSET, 32'habcd);
    rdchk(`VEL_LOW_OFFSET, 32'h1234);
    rdchk(`VEL_HIGH_OFFSET, 32'habcd);
    $display("registers done");
    apb(1'b1, `CTRL_OFFSET, 32'h0);
    steps(1'b1);
    rdchk(`POS_OFFSET, 32'h0);
    apb(1'b1, `CTRL_OFFSET, 32'h8000);
    steps(1'b1);
    rdchk(`POS_OFFSET, 32'h4);
    apb(1'b1, `CTRL_OFFSET, 32'h8008);
    steps(1'b1);
    rdchk(`POS_OFFSET, 32'h0);
    upDownOverride <= 1'b1;
    steps(1'b1);
    rdchk(`POS_OFFSET, 32'h4);
    upDownOverride <= 1'b0;
    apb(1'b1, `CTRL_OFFSET, 32'ha000);
    idleMode <= 1'b1;
    steps(1'b1);
    rdchk(`POS_OFFSET, 32'h4);
    idleMode <= 1'b0;
    steps(1'b1);
    rdchk(`POS_OFFSET, 32'h8);
    $display("counting done");
    p = 32'h8;
    apb(1'b1, `INIT_OFFSET, 32'h55);
    foreach (rows[i]) begin
      apb(1'b1, `CTRL_OFFSET, {16'h0, 3'b100, rows[i][2:0], rows[i][4:3], 8'h00});
      steps(1'b1);
      p = p + 32'h4;
      i_encoder_model.pulse(1'b1);
      i_encoder_model.pulse(1'b0);
      if (rows[i][4:3] == 2'b00 && (rows[i][2:0] == 3'h1 || rows[i][2:0] == 3'h7)) p = 32'h0;
      if (rows[i][4:3] == 2'b00 && (rows[i][2:0] == 3'h2 || rows[i][2:0] == 3'h3)) p = 32'h55;
      rdchk(`POS_OFFSET, p);
    end
    $display("index modes done");
    apb(1'b1, `CTRL_OFFSET, 32'h9000);
    i_encoder_model.pulse(1'b1);
    i_encoder_model.pulse(1'b0);
    rdchk(`POS_OFFSET, 32'h4);
    i_encoder_model.pulse(1'b0);
    rdchk(`POS_OFFSET, 32'h55);
    @(posedge clk);
    velocityCapture <= 1'b1;
    repeat (2) @(posedge clk);
    velocityCapture <= 1'b0;
    repeat (4) @(posedge clk);
    rdchk(`VEL_LOW_OFFSET, 32'h2c);
    rdchk(`VEL_HIGH_OFFSET, 32'h0);
    $display("capture done");
    report_and_stop;
  end
endmodule // encoder_control_tb
